// ---- src/mopwm_consts.svh ----
// Purpose: Offsets, field positions and reset values of the PWM timer.
// Assumes: Byte addresses on an AXI4-Lite bus with 32-bit data.
// Notes:   Definitions only; included by its bare name.
`ifndef MOPWM_CONSTS_SVH
`define MOPWM_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MOPWM_AW 8
`define MOPWM_OFS_CTRL 8'h00
`define MOPWM_OFS_COUNT 8'h04
`define MOPWM_OFS_PRESCALE 8'h08
`define MOPWM_OFS_PRECOUNT 8'h0C
`define MOPWM_OFS_ACTION 8'h10
`define MOPWM_OFS_OUTCFG 8'h14
`define MOPWM_OFS_RELEASE 8'h18
`define MOPWM_OFS_STATUS 8'h1C
`define MOPWM_OFS_MASK 8'h20
`define MOPWM_OFS_OUTLVL 8'h24
// Staging copies of the match values: base + 4 * index
`define MOPWM_OFS_MATCH 8'h40

// ****************************************************************
// Field positions and values
// ****************************************************************
`define MOPWM_CTRL_EN 0
`define MOPWM_CTRL_CRST 1
`define MOPWM_CTRL_PWM 2
// Action register: three bits per match, interrupt / reset / stop
`define MOPWM_ACT_INT 0
`define MOPWM_ACT_RST 1
`define MOPWM_ACT_STOP 2
// Output config: double-edge selects low, output enables from here
`define MOPWM_OUTCFG_OE 16
`define MOPWM_RST_VAL 32'h0000_0000
`define MOPWM_RESP_OKAY 2'h0
`define MOPWM_RESP_SLVERR 2'h2

`endif

// ---- src/mopwm_pkg.sv ----
// Purpose: Types shared by the PWM timer.
// Assumes: Constants live in mopwm_consts.svh.
// Notes:   Enumerations only.
package mopwm_pkg;

    // ************************************************************
    // Write channel states
    // ************************************************************
    typedef enum logic [1:0]
    {
        WS_IDLE = 2'b00,
        WS_ADDR = 2'b01,
        WS_DATA = 2'b10,
        WS_RESP = 2'b11
    } mopwm_wst_t;

endpackage

// ---- src/mopwm_top.sv ----
// Purpose: Multi-output PWM timer with prescaler, match actions, IRQ.
// Assumes: One clock aclk at 125 MHz, synchronous active-low reset.
// Notes:   Registers reached over AXI4-Lite.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "mopwm_consts.svh"

module mopwm_top
#(
    parameter int NUM_MATCH = 7 // Match registers, outputs is one less
)
(
    input wire logic aclk, // Clock, 125 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [`MOPWM_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [`MOPWM_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [NUM_MATCH-2:0] pwm_out, // PWM outputs 1..NUM_MATCH-1
    output logic irq // Interrupt, high while unmasked flag set
);
    import mopwm_pkg::*;

    localparam int N = NUM_MATCH;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    // Action register holds three bits per match in one word
    if (N < 2 || N > 10)
    begin : g_bad_param
        $error("NUM_MATCH must lie between 2 and 10");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        mopwm_wst_t wst;
        logic [`MOPWM_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] ctrl;
        logic [31:0] tc;
        logic [31:0] pr;
        logic [31:0] pc;
        logic [3*N-1:0] act_cfg;
        logic [31:0] outcfg;
        logic [N-1:0] rel;
        logic [N-1:0] flag;
        logic [N-1:0] mask;
        logic [N-1:0][31:0] stg;
        logic [N-1:0][31:0] mval;
        logic [N-2:0] pwm;
    } mopwm_st_t;

    mopwm_st_t st_r;
    mopwm_st_t st_nxt;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Pick one action bit of every match from the action register
    function automatic logic [N-1:0] act_bits(
        input logic [3*N-1:0] cfg,
        input int k
    );
        logic [N-1:0] v;
        v = '0;
        for (int i = 0; i < N; i++)
        begin
            v[i] = cfg[3*i+k];
        end
        return v;
    endfunction

    // Merge write data into an old word under byte strobes
    function automatic logic [31:0] wmerge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] v;
        v = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                v[8*b+:8] = data[8*b+:8];
            end
        end
        return v;
    endfunction

    // Staging slot hit by an address, N when none
    function automatic int match_slot(input logic [`MOPWM_AW-1:0] a);
        int s;
        s = N;
        if (a[7:6] == 2'b01 && a[1:0] == 2'b00 && int'(a[5:2]) < N)
        begin
            s = int'(a[5:2]);
        end
        return s;
    endfunction

    // ************************************************************
    // Counter tick and match events
    // ************************************************************
    logic cnt_en;
    logic cnt_hold;
    logic pwm_mode;
    logic tick;
    logic [N-1:0] match;
    logic [N-1:0] int_sel;
    logic [N-1:0] rst_sel;
    logic [N-1:0] stop_sel;
    logic tc_clear;
    logic stop_hit;
    logic [N-2:0] pwm_next;

    assign cnt_en = st_r.ctrl[`MOPWM_CTRL_EN];
    assign cnt_hold = st_r.ctrl[`MOPWM_CTRL_CRST];
    assign pwm_mode = st_r.ctrl[`MOPWM_CTRL_PWM];
    // One count per prescale wrap, so period is (pr + 1) clocks;
    // a prescale lowered under the running count wraps at once
    // instead of stalling for a full 32-bit lap
    assign tick = cnt_en && !cnt_hold && (st_r.pc >= st_r.pr);
    assign int_sel = act_bits(st_r.act_cfg, `MOPWM_ACT_INT);
    assign rst_sel = act_bits(st_r.act_cfg, `MOPWM_ACT_RST);
    assign stop_sel = act_bits(st_r.act_cfg, `MOPWM_ACT_STOP);
    // Match 0 always closes the cycle in PWM mode
    assign tc_clear = |(match & rst_sel) || (pwm_mode && match[0]);
    assign stop_hit = |(match & stop_sel);

    // Each comparator fires on the tick that leaves its count
    for (genvar i = 0; i < N; i++)
    begin : g_match
        assign match[i] = tick && (st_r.tc == st_r.mval[i]);
    end

    // Output k: single-edge rises at match 0, double-edge at k-1;
    // falling match wins a tie so equal values give a low output
    for (genvar k = 1; k < N; k++)
    begin : g_pwm
        logic dbl;
        logic set_ev;
        logic clr_ev;
        assign dbl = (k >= 2) && st_r.outcfg[k-1];
        assign set_ev = dbl ? match[k-1] : match[0];
        assign clr_ev = match[k];
        assign pwm_next[k-1] = (!pwm_mode
            || !st_r.outcfg[`MOPWM_OUTCFG_OE+k-1]) ? 1'b0
            : clr_ev ? 1'b0
            : set_ev ? 1'b1
            : st_r.pwm[k-1];
    end

    // ************************************************************
    // Bus handshakes
    // ************************************************************
    // Address and data may arrive in either order
    assign s_axi_awready = (st_r.wst == WS_IDLE) || (st_r.wst == WS_DATA);
    assign s_axi_wready = (st_r.wst == WS_IDLE) || (st_r.wst == WS_ADDR);
    assign s_axi_bvalid = (st_r.wst == WS_RESP);
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign pwm_out = st_r.pwm;
    assign irq = |(st_r.flag & st_r.mask);

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic do_wr;
        logic [`MOPWM_AW-1:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [31:0] w32;
        logic [31:0] rd;
        logic hit;
        int slot;
        do_wr = 1'b0;
        wa = aw_hs ? s_axi_awaddr : st_r.awaddr;
        wd = w_hs ? s_axi_wdata : st_r.wdata;
        ws = w_hs ? s_axi_wstrb : st_r.wstrb;
        w32 = '0;
        rd = '0;
        hit = 1'b1;
        slot = N;
        st_nxt = st_r;

        // Write channel
        case (st_r.wst)
            WS_IDLE:
            begin
                if (aw_hs && w_hs)
                begin
                    do_wr = 1'b1;
                end
                else if (aw_hs)
                begin
                    st_nxt.wst = WS_ADDR;
                end
                else if (w_hs)
                begin
                    st_nxt.wst = WS_DATA;
                end
            end
            WS_ADDR:
            begin
                do_wr = w_hs;
            end
            WS_DATA:
            begin
                do_wr = aw_hs;
            end
            WS_RESP:
            begin
                if (s_axi_bready)
                begin
                    st_nxt.wst = WS_IDLE;
                end
            end
            default:
            begin
                st_nxt.wst = WS_IDLE;
            end
        endcase
        if (aw_hs)
        begin
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (w_hs)
        begin
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end

        // Prescaler and counter
        if (cnt_hold)
        begin
            st_nxt.pc = '0;
            st_nxt.tc = '0;
        end
        else if (tick)
        begin
            st_nxt.pc = '0;
            st_nxt.tc = tc_clear ? '0 : st_r.tc + 32'h0000_0001;
        end
        else if (cnt_en)
        begin
            st_nxt.pc = st_r.pc + 32'h0000_0001;
        end
        if (stop_hit)
        begin
            st_nxt.ctrl[`MOPWM_CTRL_EN] = 1'b0;
        end

        // Released values load only when a new cycle starts
        if (pwm_mode && match[0])
        begin
            for (int i = 0; i < N; i++)
            begin
                if (st_r.rel[i])
                begin
                    st_nxt.mval[i] = st_r.stg[i];
                end
            end
            st_nxt.rel = '0;
        end
        st_nxt.pwm = pwm_next;

        // Register writes
        w32 = wmerge(`MOPWM_RST_VAL, wd, ws);
        slot = match_slot(wa);
        if (do_wr)
        begin
            st_nxt.wst = WS_RESP;
            st_nxt.bresp = `MOPWM_RESP_OKAY;
            case (wa)
                `MOPWM_OFS_CTRL: st_nxt.ctrl = w32[2:0];
                `MOPWM_OFS_PRESCALE: st_nxt.pr = wmerge(st_r.pr, wd, ws);
                `MOPWM_OFS_ACTION: st_nxt.act_cfg = w32[3*N-1:0];
                `MOPWM_OFS_OUTCFG: st_nxt.outcfg = wmerge(st_r.outcfg, wd, ws);
                // Software sets release bits; hardware only clears them
                `MOPWM_OFS_RELEASE: st_nxt.rel = st_nxt.rel | w32[N-1:0];
                `MOPWM_OFS_STATUS: st_nxt.flag = st_r.flag & ~w32[N-1:0];
                `MOPWM_OFS_MASK: st_nxt.mask = w32[N-1:0];
                default:
                begin
                    if (slot < N)
                    begin
                        st_nxt.stg[slot] = wmerge(st_r.stg[slot], wd, ws);
                        // Plain timer mode takes the value at once
                        if (!pwm_mode)
                        begin
                            st_nxt.mval[slot] = st_nxt.stg[slot];
                        end
                    end
                    else
                    begin
                        st_nxt.bresp = `MOPWM_RESP_SLVERR;
                    end
                end
            endcase
        end

        // Sticky flags: a new match wins over a same-cycle clear
        st_nxt.flag = st_nxt.flag | (match & int_sel);

        // Read channel
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_hs)
        begin
            slot = match_slot(s_axi_araddr);
            case (s_axi_araddr)
                `MOPWM_OFS_CTRL: rd[2:0] = st_r.ctrl;
                `MOPWM_OFS_COUNT: rd = st_r.tc;
                `MOPWM_OFS_PRESCALE: rd = st_r.pr;
                `MOPWM_OFS_PRECOUNT: rd = st_r.pc;
                `MOPWM_OFS_ACTION: rd[3*N-1:0] = st_r.act_cfg;
                `MOPWM_OFS_OUTCFG: rd = st_r.outcfg;
                `MOPWM_OFS_RELEASE: rd[N-1:0] = st_r.rel;
                `MOPWM_OFS_STATUS: rd[N-1:0] = st_r.flag;
                `MOPWM_OFS_MASK: rd[N-1:0] = st_r.mask;
                `MOPWM_OFS_OUTLVL: rd[N-2:0] = st_r.pwm;
                default:
                begin
                    if (slot < N)
                    begin
                        rd = st_r.stg[slot];
                    end
                    else
                    begin
                        hit = 1'b0;
                    end
                end
            endcase
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd;
            st_nxt.rresp = hit ? `MOPWM_RESP_OKAY : `MOPWM_RESP_SLVERR;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Bus write landing this cycle; a register write lands after the
    // hardware events of the same cycle and so may override them
    logic wr_go;
    logic ctrl_wr;
    assign wr_go = ((st_r.wst == WS_IDLE) && aw_hs && w_hs)
        || ((st_r.wst == WS_ADDR) && w_hs)
        || ((st_r.wst == WS_DATA) && aw_hs);
    assign ctrl_wr = wr_go
        && ((aw_hs ? s_axi_awaddr : st_r.awaddr) == `MOPWM_OFS_CTRL);

    sequence s_cycle_start;
        pwm_mode && match[0];
    endsequence

    a_count_step: assert property (tick && !tc_clear && !cnt_hold
        |=> st_r.tc == $past(st_r.tc) + 32'h0000_0001)
        else $error("counter did not advance on tick");
    a_prescale_wait: assert property (cnt_en && !cnt_hold && !tick
        |=> st_r.tc == $past(st_r.tc)
            && st_r.pc == $past(st_r.pc) + 32'h0000_0001)
        else $error("prescaler or counter misstepped");
    a_period_reset: assert property (s_cycle_start
        |=> st_r.tc == 32'h0000_0000)
        else $error("period match did not clear counter");
    a_match_reset: assert property (|(match & rst_sel) && !cnt_hold
        |=> st_r.tc == 32'h0000_0000)
        else $error("reset on match ignored");
    a_match_stop: assert property (stop_hit && !ctrl_wr
        |=> !cnt_en)
        else $error("stop on match ignored");
    a_flag_set: assert property (|(match & int_sel)
        |=> (st_r.flag & $past(match & int_sel))
            == $past(match & int_sel))
        else $error("match flag not raised");
    a_single_rise: assert property (s_cycle_start ##0 (!wr_go
        && st_r.outcfg[`MOPWM_OUTCFG_OE] && !match[1])
        |=> pwm_out[0] ##1 (pwm_out[0] || $past(match[1])))
        else $error("single-edge output failed to rise");

    // The double-edge check watches output 3, which needs N of 4 or more
    if (N >= 4)
    begin : g_dbl_chk
        a_double_rise: assert property (pwm_mode && st_r.outcfg[2]
            && st_r.outcfg[`MOPWM_OUTCFG_OE+2] && match[2] && !match[3]
            |=> pwm_out[2])
            else $error("double-edge output failed to rise");
    end

    a_release_load: assert property (s_cycle_start
        ##0 (st_r.rel[1] && !wr_go)
        |=> st_r.mval[1] == $past(st_r.stg[1]) && !st_r.rel[1])
        else $error("released value not loaded at cycle start");
    a_hold_active: assert property (pwm_mode && !match[0]
        |=> st_r.mval == $past(st_r.mval))
        else $error("active match changed mid-cycle");
    a_timer_quiet: assert property (!pwm_mode
        |=> pwm_out == '0)
        else $error("outputs driven outside PWM mode");
endmodule

// ---- test/mopwm_load.sv ----
// Purpose: Load model that watches the PWM pins of the timer.
// Assumes: One clock; pins are sampled at its rising edge.
// Notes:   Counts high cycles and rising edges over a window.
`timescale 1ns/1ps

module mopwm_load
#(
    parameter int N = 6 // Number of PWM pins watched
)
(
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic clr, // Restart the measuring window
    input wire logic [N-1:0] pwm, // PWM pins from the block
    output logic [15:0] hi [N], // High cycles seen in the window
    output logic [15:0] rise [N] // Rising edges seen in the window
);
    logic [N-1:0] prev;

    // A window of whole periods makes the sums phase independent
    always_ff @(posedge clk)
    begin
        prev <= pwm;
        for (int k = 0; k < N; k++)
        begin
            if (!rst_n || clr)
            begin
                hi[k] <= 16'h0000;
                rise[k] <= 16'h0000;
            end
            else
            begin
                hi[k] <= hi[k] + {15'h0000, pwm[k]};
                rise[k] <= rise[k] + {15'h0000, pwm[k] & ~prev[k]};
            end
        end
    end
endmodule

// ---- test/tb_multi_output_pwm_timer.sv ----
// Purpose: Self-checking bench of the multi-output PWM timer.
// Assumes: Registers reached over AXI4-Lite at 125 MHz.
// Notes:   Expected pulse times follow from prescale and match values.
`timescale 1ns/1ps
`include "mopwm_consts.svh"

module tb_multi_output_pwm_timer;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [5:0] pwm_out;
    logic irq;
    logic clr = 1'b0;
    logic [15:0] hi [6];
    logic [15:0] rise [6];
    int compares = 0;
    int n_mismatch = 0;
    int cycles = 0;

    mopwm_top #(.NUM_MATCH(7)) u_mopwm_top
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_out(pwm_out), .irq(irq)
    );

    mopwm_load #(.N(6)) u_mopwm_load
    (
        .clk(aclk), .rst_n(aresetn), .clr(clr), .pwm(pwm_out),
        .hi(hi), .rise(rise)
    );

    // 125 MHz clock
    always #4 aclk = ~aclk;

    // Hang guard; the whole run needs under a thousand cycles
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // ************************************************************
    // Bus and comparison helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Only the hang guard ends a wait for the answer
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk({30'h0, r}, 32'h0, "write response");
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string what);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(d, e, what);
        chk({30'h0, r}, 32'h0, "read response");
    endtask

    // 100 cycles is five whole periods of the 20-cycle PWM cycle
    task automatic measure(input int e [6]);
        repeat (60) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (100) @(posedge aclk);
        #1;
        for (int k = 0; k < 6; k++)
        begin
            chk({16'h0, hi[k]}, 32'(5 * e[k]), "high cycles");
            chk({16'h0, rise[k]}, (e[k] > 0) ? 32'h5 : 32'h0, "rises");
        end
        @(posedge aclk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_map();
        logic [31:0] d;
        logic [1:0] r;
        chk({26'h0, pwm_out}, 32'h0, "pwm after reset");
        rdc(`MOPWM_OFS_CTRL, 32'h0, "ctrl after reset");
        axr(8'h30, d, r);
        chk(d, 32'h0, "unmapped read data");
        chk({30'h0, r}, {30'h0, `MOPWM_RESP_SLVERR}, "unmapped read");
        axw(8'h30, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, `MOPWM_RESP_SLVERR}, "unmapped write");
    endtask

    // Match 2 only flags, match 1 flags, resets and stops the count
    task automatic t_actions();
        int i;
        wr(`MOPWM_OFS_PRESCALE, 32'h3);
        wr(`MOPWM_OFS_MATCH + 8'h04, 32'h5);
        wr(`MOPWM_OFS_MATCH + 8'h08, 32'h2);
        wr(`MOPWM_OFS_ACTION, 32'h78);
        wr(`MOPWM_OFS_MASK, 32'h2);
        wr(`MOPWM_OFS_CTRL, 32'h1);
        for (i = 0; i < 300 && irq !== 1'b1; i++)
            @(posedge aclk);
        chk({31'h0, irq}, 32'h1, "irq on match");
        rdc(`MOPWM_OFS_COUNT, 32'h0, "count reset on match");
        rdc(`MOPWM_OFS_CTRL, 32'h0, "stopped on match");
        rdc(`MOPWM_OFS_STATUS, 32'h6, "flags of both matches");
        wr(`MOPWM_OFS_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(`MOPWM_OFS_MASK, 32'h2);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(`MOPWM_OFS_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rdc(`MOPWM_OFS_STATUS, 32'h4, "other flag kept");
        wr(`MOPWM_OFS_STATUS, 32'h4);
        wr(`MOPWM_OFS_ACTION, 32'h0);
    endtask

    // Outputs 1,2,4,6 single edge, 3 and 5 double edge, 6 held low
    task automatic t_pwm();
        int m [7] = '{9, 3, 2, 6, 7, 1, 9};
        wr(`MOPWM_OFS_PRESCALE, 32'h1);
        for (int i = 0; i < 7; i++)
            wr(`MOPWM_OFS_MATCH + 8'(4 * i), 32'(m[i]));
        for (int i = 0; i < 7; i++)
            rdc(`MOPWM_OFS_MATCH + 8'(4 * i), 32'(m[i]), "staged");
        wr(`MOPWM_OFS_OUTCFG, 32'h003F_0014);
        wr(`MOPWM_OFS_CTRL, 32'h5);
        measure('{8, 6, 8, 16, 8, 0});
    endtask

    // A staged value must not act before release and cycle start
    task automatic t_release();
        wr(`MOPWM_OFS_MATCH + 8'h04, 32'h5);
        measure('{8, 6, 8, 16, 8, 0});
        wr(`MOPWM_OFS_RELEASE, 32'h2);
        repeat (30) @(posedge aclk);
        rdc(`MOPWM_OFS_RELEASE, 32'h0, "release self-clears");
        measure('{12, 6, 8, 16, 8, 0});
    endtask

    // Plain timer: match 0 resets and flags, pins stay low
    task automatic t_timer();
        wr(`MOPWM_OFS_ACTION, 32'h3);
        wr(`MOPWM_OFS_MASK, 32'h1);
        wr(`MOPWM_OFS_CTRL, 32'h1);
        repeat (40) @(posedge aclk);
        chk({26'h0, pwm_out}, 32'h0, "pins idle as timer");
        chk({31'h0, irq}, 32'h1, "match flag as timer");
        // Hold-at-zero keeps both counters cleared while enabled
        wr(`MOPWM_OFS_CTRL, 32'h3);
        repeat (10) @(posedge aclk);
        rdc(`MOPWM_OFS_COUNT, 32'h0, "count held at zero");
        rdc(`MOPWM_OFS_PRECOUNT, 32'h0, "prescaler held");
        wr(`MOPWM_OFS_CTRL, 32'h0);
        wr(`MOPWM_OFS_STATUS, 32'h7F);
        chk({31'h0, irq}, 32'h0, "irq cleared");
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_map();
        t_actions();
        t_pwm();
        t_release();
        t_timer();
        complete_run();
    end
endmodule
